// ==== verilog/ports_cfg.svh ====
// Register map, field positions and timing constants for the port block
// Function
// (R1) Codec sample is 8 bits with companding, otherwise 16 bits.
// (R2) Serial words shift most significant bit first, down to bit 0.
// (R3) Codec mode captures receive data on receive clock rising edge.
// (R4) Codec mode updates transmit data so the codec samples on falling edge.
// (R5) Codec drives both serial clocks and both frames; all inputs here.
// (R6) Board ties transmit and receive clocks, and both frames, together.
// (R7) Packet mode sends on transmit pins and receives on receive pins.
// (R8) Packet mode frame pulse delimits exactly 8 data bits each way.
// (R9) Packet mode captures receive data on receive clock falling edge.
// (R10) Packet mode updates transmit data and frame after transmit clock rise.
// (R11) Packet mode receive clock and frame are inputs; transmit ones outputs.
// (R12) Three-bit rate select sets transmit clock from 28,800 to 921,600 Hz.
// (R13) Far end supplies receive clock between 28,000 and 921,600 Hz.
// (R14) Parallel port is asynchronous, 8-bit bidirectional, handshaken.
// (R15) Parallel packet interface in use: serial port carries no packets.
// (R16) Parallel port: channel data in codec mode, everything in packet mode.
// (R17) Transmit-available flag is high while packet data waits to be read.
// (R18) Read: request low, ack low with data, request high, ack high.
// (R19) Write: data, request low, capture and ack low, request high, ack high.
// (R20) Serial port is either codec or packet interface, never both.
// (R21) Parallel requests are synchronised before any acknowledge decision.
// (R22) Frame marks word start; first data bit on next active edge.
`ifndef PORTS_CFG_SVH
`define PORTS_CFG_SVH
`define CTRL_OFS 8'h00
`define STATUS_OFS 8'h04
`define SER_TX_OFS 8'h08
`define SER_RX_OFS 8'h0c
`define PAR_TX_OFS 8'h10
`define PAR_RX_OFS 8'h14
`define CTRL_PACKET 0
`define CTRL_COMPAND 1
`define CTRL_RATE_LO 2
`define CTRL_RATE_HI 4
`define CTRL_PAR_SEL 5
`define CTRL_RESET 6'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define WORD_COMPAND 5'h08
`define WORD_LINEAR 5'h10
`define PKT_BITS 5'h08
`define SYNC_W 15
`define SYNC_INIT 15'h0060
`define CLK_HZ 25000000
`define RATE0_HZ 28800
`define RATE1_HZ 57600
`define RATE2_HZ 115200
`define RATE3_HZ 230400
`define RATE4_HZ 460800
`define RATE5_HZ 921600
`define HALF_CNT(hz) (`CLK_HZ / (2 * (hz)))
`endif

// ==== verilog/port_types_pkg.sv ====
// Shared types for the serial and parallel port block
package port_types_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [15:0] word_t;
    typedef enum logic [1:0] {P_IDLE, P_RD_DATA, P_RD_ACK, P_WR_ACK} par_state_t;
endpackage

// ==== verilog/sync_if.sv ====
// Raw and settled pin levels between the port block and its synchroniser
`timescale 1ns/1ps
`include "ports_cfg.svh"
interface sync_if;
    logic [`SYNC_W-1:0] raw;
    logic [`SYNC_W-1:0] stable;
    modport sync (input raw, output stable);
    modport user (output raw, input stable);
endinterface // sync_if

// ==== verilog/pin_sync.sv ====
// Three-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`include "ports_cfg.svh"
module pin_sync (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    sync_if.sync pins
);
    localparam logic [`SYNC_W-1:0] INIT = `SYNC_INIT;
    logic [`SYNC_W-1:0] s1;
    logic [`SYNC_W-1:0] s2;
    logic [`SYNC_W-1:0] s3;
    genvar i;
    generate
        for (i = 0; i < `SYNC_W; i++) begin : g_bit
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    s1[i] <= INIT[i];
                    s2[i] <= INIT[i];
                    s3[i] <= INIT[i];
                    pins.stable[i] <= INIT[i];
                end else if (ce) begin
                    s1[i] <= pins.raw[i];
                    s2[i] <= s1[i];
                    s3[i] <= s2[i];
                    // Change accepted only once two late stages agree
                    if (s2[i] == s3[i]) pins.stable[i] <= s3[i]; // [R21]
                end
            end
        end
    endgenerate
endmodule // pin_sync

// ==== verilog/tx_clock_gen.sv ====
// Packet-mode transmit clock divider
`timescale 1ns/1ps
`include "ports_cfg.svh"
module tx_clock_gen (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire run,
    input wire [2:0] rate_sel,
    output logic level,
    output logic rise
);
    logic [8:0] half;
    logic [8:0] count;
    logic [8:0] half_q;
    logic [9:0] gap;
    logic gap_ok;
    // Unused codes fall back to the slowest rate
    assign half = (rate_sel == 3'h1) ? 9'(`HALF_CNT(`RATE1_HZ)) :
                  (rate_sel == 3'h2) ? 9'(`HALF_CNT(`RATE2_HZ)) :
                  (rate_sel == 3'h3) ? 9'(`HALF_CNT(`RATE3_HZ)) :
                  (rate_sel == 3'h4) ? 9'(`HALF_CNT(`RATE4_HZ)) :
                  (rate_sel == 3'h5) ? 9'(`HALF_CNT(`RATE5_HZ)) :
                  9'(`HALF_CNT(`RATE0_HZ)); // [R12]
    wire at_end = (count == 9'h000);
    // Early flag so the caller updates on the same edge the clock rises
    assign rise = run && at_end && !level;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 9'h000;
            level <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                count <= 9'h000;
                level <= 1'b0;
            end else if (at_end) begin
                count <= half - 9'h001; // [R12]
                level <= !level;
            end else begin
                count <= count - 9'h001;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap <= 10'h000;
            gap_ok <= 1'b0;
            half_q <= 9'h000;
        end else if (ce) begin
            half_q <= half;
            if (!run || half != half_q) begin
                gap <= 10'h000;
                gap_ok <= 1'b0;
            end else if (rise) begin
                gap <= 10'h001;
                gap_ok <= 1'b1;
            end else begin
                gap <= gap + 10'h001;
            end
        end
    end
    rate_period_a: assert property (@(posedge aclk) // [R12]
        disable iff (!aresetn) ce && rise && gap_ok |-> gap == {half, 1'b0})
        else $error("Transmit clock period does not match rate select");
endmodule // tx_clock_gen

// ==== verilog/vocoder_ports.sv ====
// Framed serial port and handshaken parallel port with AXI4-Lite registers
`timescale 1ns/1ps
`include "ports_cfg.svh"
module vocoder_ports (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire [7:0] awaddr,
    input wire awvalid,
    output logic awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire rready,
    input wire serial_rx_data,
    input wire serial_rx_clock,
    input wire serial_rx_frame,
    output logic serial_tx_data,
    input wire serial_tx_clock_in,
    output logic serial_tx_clock_out,
    output logic serial_tx_clock_oe_n,
    input wire serial_tx_frame_in,
    output logic serial_tx_frame_out,
    output logic serial_tx_frame_oe_n,
    input port_types_pkg::byte_t parallel_data_in,
    output port_types_pkg::byte_t parallel_data_out,
    output logic parallel_data_oe_n,
    input wire parallel_read_req_n,
    input wire parallel_write_req_n,
    output logic parallel_ack_n,
    output logic tx_available
);
    import port_types_pkg::*;

    sync_if pins();
    logic [5:0] ctrl;
    word_t ser_tx_word;
    word_t ser_rx_word;
    word_t rx_shift;
    word_t tx_shift;
    logic ser_tx_pending;
    logic ser_rx_valid;
    logic ser_rx_overrun;
    byte_t par_tx_byte;
    byte_t par_rx_byte;
    logic par_rx_valid;
    par_state_t par_state;
    logic [4:0] rx_count;
    logic [4:0] tx_count;
    logic rx_clock_q;
    logic tx_clock_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic aw_full;
    logic w_full;
    logic gen_level;
    logic gen_rise;

    // Every outside pin goes through the same three stages
    assign pins.raw = {parallel_data_in, parallel_write_req_n,
                       parallel_read_req_n, serial_tx_frame_in,
                       serial_tx_clock_in, serial_rx_frame,
                       serial_rx_clock, serial_rx_data}; // [R21]

    pin_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .pins(pins)
    );

    wire s_rxd = pins.stable[0];
    wire s_rxclk = pins.stable[1];
    wire s_rxfs = pins.stable[2];
    wire s_txclk = pins.stable[3];
    wire s_txfs = pins.stable[4];
    wire rd_req = !pins.stable[5];
    wire wr_req = !pins.stable[6];
    byte_t s_bus;
    assign s_bus = pins.stable[14:7];

    wire packet_mode = ctrl[`CTRL_PACKET];
    wire compand = ctrl[`CTRL_COMPAND];
    wire [2:0] rate_sel = ctrl[`CTRL_RATE_HI:`CTRL_RATE_LO];
    wire par_sel = ctrl[`CTRL_PAR_SEL];
    // Serial packets stop when the parallel port owns the packet stream
    wire ser_enable = !(packet_mode && par_sel); // [R15] [R20]
    wire [4:0] width = packet_mode ? `PKT_BITS :
                       (compand ? `WORD_COMPAND : `WORD_LINEAR); // [R1] [R8]

    tx_clock_gen u_txclk (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .run(packet_mode && ser_enable),
        .rate_sel(rate_sel),
        .level(gen_level),
        .rise(gen_rise)
    );

    wire rx_rise = s_rxclk && !rx_clock_q;
    wire rx_fall = !s_rxclk && rx_clock_q;
    wire tx_rise_in = s_txclk && !tx_clock_q;
    wire tx_fall_in = !s_txclk && tx_clock_q;
    wire rx_edge = ser_enable && (packet_mode ? rx_fall : rx_rise); // [R3] [R9]
    // Codec clocks are tied, so the transmit input clock stands for both
    wire tx_edge = ser_enable &&
                   (packet_mode ? gen_rise : tx_rise_in); // [R4] [R6] [R10]
    // Codec bits launch on the fall: sync delay would miss the next fall
    wire tx_bit_edge = ser_enable &&
                       (packet_mode ? gen_rise : tx_fall_in); // [R4] [R10]
    wire tx_start = packet_mode ? ser_tx_pending : s_txfs; // [R7] [R22]
    wire rx_done = rx_edge && (rx_count == 5'h01);
    wire tx_load = tx_edge && (tx_count == 5'h00) && tx_start;
    word_t rx_next;
    assign rx_next = {rx_shift[14:0], s_rxd}; // [R2]
    word_t tx_fill;
    assign tx_fill = (width == `WORD_LINEAR) ? ser_tx_word :
                     {ser_tx_word[7:0], 8'h00}; // [R2]

    wire do_write = aw_full && w_full && !bvalid;
    wire do_read = arvalid && arready;
    wire wr_ctrl = do_write && (aw_addr_q == `CTRL_OFS);
    wire wr_ser_tx = do_write && (aw_addr_q == `SER_TX_OFS);
    wire wr_par_tx = do_write && (aw_addr_q == `PAR_TX_OFS);
    wire wr_hit = wr_ctrl || wr_ser_tx || wr_par_tx;
    wire rd_ser_rx = do_read && (araddr == `SER_RX_OFS);
    wire rd_par_rx = do_read && (araddr == `PAR_RX_OFS);
    wire [7:0] status = {3'h0, ser_rx_overrun, par_rx_valid, tx_available,
                         ser_rx_valid, ser_tx_pending};
    wire rd_hit = (araddr == `CTRL_OFS) || (araddr == `STATUS_OFS) ||
                  (araddr == `SER_TX_OFS) || (araddr == `SER_RX_OFS) ||
                  (araddr == `PAR_TX_OFS) || (araddr == `PAR_RX_OFS);
    logic [31:0] rd_mux;
    assign rd_mux = (araddr == `CTRL_OFS) ? 32'(ctrl) :
                    (araddr == `STATUS_OFS) ? 32'(status) :
                    (araddr == `SER_TX_OFS) ? 32'(ser_tx_word) :
                    (araddr == `SER_RX_OFS) ? 32'(ser_rx_word) :
                    (araddr == `PAR_TX_OFS) ? 32'(par_tx_byte) :
                    (araddr == `PAR_RX_OFS) ? 32'(par_rx_byte) :
                    32'h0000_0000;

    // Read wins over write when both requests settle together
    wire par_rd_start = (par_state == P_IDLE) && rd_req && tx_available;
    wire par_wr_take = (par_state == P_IDLE) && !rd_req && wr_req &&
                       !par_rx_valid;
    wire par_rd_done = (par_state == P_RD_ACK) && !rd_req;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_addr_q <= awaddr;
                aw_full <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
                w_full <= 1'b1;
                wready <= 1'b0;
            end
            if (do_write) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else if (ce) begin
            if (do_read) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_mux;
                rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `CTRL_RESET;
            ser_tx_word <= 16'h0000;
            par_tx_byte <= 8'h00;
        end else if (ce) begin
            if (wr_ctrl && w_strb_q[0]) ctrl <= w_data_q[5:0]; // [R20]
            if (wr_ser_tx && w_strb_q[0]) ser_tx_word[7:0] <= w_data_q[7:0];
            if (wr_ser_tx && w_strb_q[1]) ser_tx_word[15:8] <= w_data_q[15:8];
            if (wr_par_tx && w_strb_q[0]) par_tx_byte <= w_data_q[7:0];
        end
    end

    // Receive: frame seen on one active edge, data on the following ones
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_clock_q <= 1'b0;
            rx_count <= 5'h00;
            rx_shift <= 16'h0000;
            ser_rx_word <= 16'h0000;
            ser_rx_valid <= 1'b0;
            ser_rx_overrun <= 1'b0;
        end else if (ce) begin
            rx_clock_q <= s_rxclk;
            if (rd_ser_rx) begin
                ser_rx_valid <= 1'b0;
                ser_rx_overrun <= 1'b0;
            end
            if (rx_edge && rx_count != 5'h00) begin
                rx_shift <= rx_next; // [R2] [R3] [R9]
                rx_count <= rx_count - 5'h01;
            end else if (rx_edge && s_rxfs) begin
                rx_shift <= 16'h0000;
                rx_count <= width; // [R1] [R8] [R22]
            end
            if (rx_done) begin
                ser_rx_word <= rx_next;
                ser_rx_valid <= 1'b1;
                if (ser_rx_valid && !rd_ser_rx) ser_rx_overrun <= 1'b1;
            end
        end
    end

    // Transmit: codec mode resends the held word on every frame
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_clock_q <= 1'b0;
            tx_count <= 5'h00;
            tx_shift <= 16'h0000;
            ser_tx_pending <= 1'b0;
            serial_tx_data <= 1'b0;
            serial_tx_frame_out <= 1'b0;
        end else if (ce) begin
            tx_clock_q <= s_txclk;
            if (tx_bit_edge && tx_count != 5'h00) begin
                serial_tx_data <= tx_shift[15]; // [R2] [R4] [R10]
                tx_shift <= {tx_shift[14:0], 1'b0};
                tx_count <= tx_count - 5'h01;
                serial_tx_frame_out <= 1'b0;
            end else if (tx_load) begin
                tx_shift <= tx_fill;
                tx_count <= width; // [R1] [R8]
                serial_tx_frame_out <= packet_mode; // [R10] [R22]
                ser_tx_pending <= 1'b0;
            end else if (tx_edge) begin
                serial_tx_frame_out <= 1'b0;
            end
            if (wr_ser_tx) ser_tx_pending <= 1'b1;
        end
    end

    // Transmit clock and frame pins turn round with the mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_tx_clock_out <= 1'b0;
            serial_tx_clock_oe_n <= 1'b1;
            serial_tx_frame_oe_n <= 1'b1;
        end else if (ce) begin
            serial_tx_clock_out <= gen_level; // [R12]
            serial_tx_clock_oe_n <= !packet_mode; // [R5] [R11]
            serial_tx_frame_oe_n <= !packet_mode; // [R5] [R11]
        end
    end

    // Parallel port serves both modes; packet content is software's concern
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            par_state <= P_IDLE;
            parallel_ack_n <= 1'b1;
            parallel_data_oe_n <= 1'b1;
            parallel_data_out <= 8'h00;
            par_rx_byte <= 8'h00;
            par_rx_valid <= 1'b0;
            tx_available <= 1'b0;
        end else if (ce) begin
            if (rd_par_rx) par_rx_valid <= 1'b0;
            if (par_rd_done) tx_available <= 1'b0;
            if (wr_par_tx) tx_available <= 1'b1; // [R17]
            unique case (par_state)
                P_IDLE: begin
                    if (par_rd_start) begin
                        parallel_data_out <= par_tx_byte; // [R14] [R16]
                        parallel_data_oe_n <= 1'b0;
                        par_state <= P_RD_DATA;
                    end else if (par_wr_take) begin
                        par_rx_byte <= s_bus; // [R19]
                        par_rx_valid <= 1'b1;
                        parallel_ack_n <= 1'b0;
                        par_state <= P_WR_ACK;
                    end
                end
                P_RD_DATA: begin
                    // Data set up one cycle ahead of the acknowledge
                    parallel_ack_n <= 1'b0; // [R18]
                    par_state <= P_RD_ACK;
                end
                P_RD_ACK: begin
                    if (!rd_req) begin
                        parallel_ack_n <= 1'b1; // [R18]
                        parallel_data_oe_n <= 1'b1;
                        par_state <= P_IDLE;
                    end
                end
                P_WR_ACK: begin
                    if (!wr_req) begin
                        parallel_ack_n <= 1'b1; // [R19]
                        par_state <= P_IDLE;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ack_fall_req_a: assert property ( // [R18] [R19]
        $fell(parallel_ack_n) |-> $past(rd_req) || $past(wr_req))
        else $error("Acknowledge fell without a request");
    rd_ack_hold_a: assert property ( // [R18]
        ce && par_state == P_RD_ACK && rd_req |=> !parallel_ack_n)
        else $error("Read acknowledge released while request held");
    rd_data_drive_a: assert property ( // [R18]
        par_state == P_RD_ACK |-> !parallel_data_oe_n && !parallel_ack_n)
        else $error("Read acknowledge without driven data");
    wr_release_a: assert property ( // [R19]
        $rose(parallel_ack_n) && $past(par_state) == P_WR_ACK
        |-> !$past(wr_req))
        else $error("Write acknowledge released before request");
    wr_capture_a: assert property ( // [R19]
        par_state == P_IDLE ##1 par_state == P_WR_ACK
        |-> par_rx_valid && par_rx_byte == $past(s_bus))
        else $error("Written byte not captured");
    tx_avail_clear_a: assert property ( // [R17]
        ce && par_rd_done && !wr_par_tx |=> !tx_available)
        else $error("Transmit available stuck after read");
    pkt_frame_len_a: assert property ( // [R8]
        serial_tx_frame_out |-> tx_count == `PKT_BITS)
        else $error("Packet frame not followed by eight bits");
    codec_pins_in_a: assert property ( // [R5]
        !$past(packet_mode) |-> serial_tx_clock_oe_n && serial_tx_frame_oe_n)
        else $error("Transmit clock or frame driven in codec mode");
    pkt_pins_out_a: assert property ( // [R11]
        $past(packet_mode) |-> !serial_tx_clock_oe_n && !serial_tx_frame_oe_n)
        else $error("Transmit clock or frame not driven in packet mode");
    codec_width_a: assert property ( // [R1]
        ce && rx_edge && rx_count == 5'h00 && s_rxfs && !packet_mode
        |=> rx_count == ($past(compand) ? `WORD_COMPAND : `WORD_LINEAR))
        else $error("Codec word length does not follow companding");

    par_read_c: cover property (par_state == P_RD_ACK ##1 par_state == P_IDLE);
    par_write_c: cover property (par_state == P_WR_ACK ##1 par_state == P_IDLE);
    pkt_word_c: cover property (packet_mode && tx_load);
    codec_word_c: cover property (!packet_mode && rx_done);
endmodule // vocoder_ports

// ==== testbench/far_end.sv ====
// Far-end serial source driving the receive pins
`timescale 1ns/1ps
module far_end (
    output logic clk,
    output logic frame,
    output logic data
);
    initial begin
        clk = 1'b0;
        frame = 1'b0;
        data = 1'b0;
    end
    // Clock stands still between words; released data inverts
    task automatic send(input logic [15:0] w, input int n, input logic pos);
        int i;
        #7 clk = ~pos;
        for (i = n; i >= 0; i--) begin
            frame = (i == n);
            data = (i == n) ? ~data : w[i];
            #160 clk = ~clk;
            #160 clk = ~clk;
        end
        frame = 1'b0;
        data = ~data;
        // Pins need several port clocks to pass the synchroniser
        #320;
    endtask
endmodule // far_end

// ==== testbench/tb_top.sv ====
// Self-checking bench for the serial and parallel port block
`timescale 1ns/1ps
`include "ports_cfg.svh"
module tb_top;
    import port_types_pkg::*;
    logic aclk, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, rd_n = 1'b1, wr_n = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, txd, ack_n, oe_n;
    logic txc_o, txc_oe_n, txf_o, txf_oe_n, tx_available;
    logic [1:0] bresp, rresp;
    logic [15:0] cap;
    byte_t host_d = 8'h00, pd_out;
    wire fc, ff, fd;
    int error_cnt = 0, compares = 0, i;
    int hz[6] = '{28800, 57600, 115200, 230400, 460800, 921600};
    far_end far_end_inst (.clk(fc), .frame(ff), .data(fd));
    // Board ties both serial clocks and frames together while the port leaves its transmit clock and frame undriven
    vocoder_ports vocoder_ports_inst (.aclk(aclk), .aresetn(aresetn),
        .ce(1'b1), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .serial_rx_data(fd),
        .serial_rx_clock(fc), .serial_rx_frame(ff), .serial_tx_data(txd),
        .serial_tx_clock_in(txc_oe_n ? fc : txc_o),
        .serial_tx_clock_out(txc_o), .serial_tx_clock_oe_n(txc_oe_n),
        .serial_tx_frame_in(txf_oe_n ? ff : txf_o),
        .serial_tx_frame_out(txf_o), .serial_tx_frame_oe_n(txf_oe_n),
        .parallel_data_in(oe_n ? host_d : pd_out),
        .parallel_data_out(pd_out), .parallel_data_oe_n(oe_n),
        .parallel_read_req_n(rd_n), .parallel_write_req_n(wr_n),
        .parallel_ack_n(ack_n), .tx_available(tx_available));
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // Codec samples transmit data on falling edges
    always @(negedge fc) cap <= {cap[14:0], txd};
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
    endtask
    task automatic host(input logic w, input byte_t d);
        @(posedge aclk);
        host_d <= d;
        @(posedge aclk);
        wr_n <= !w;
        rd_n <= w;
        do @(posedge aclk); while (ack_n !== 1'b0);
        if (!w) chk({23'h0, oe_n, pd_out}, {23'h0, 1'b0, d});
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        host_d <= ~d;
        do @(posedge aclk); while (ack_n !== 1'b1);
    endtask
    // Far end samples on generated clock rises; frame, then 8 bits
    task automatic grab(input byte_t eb, input int ep);
        logic p;
        int t, last, per, k;
        byte_t b;
        p = 1'b1;
        t = 0;
        last = 0;
        per = 0;
        k = -1;
        b = 8'h00;
        while (k < 8) begin
            @(posedge aclk);
            #1;
            t++;
            if (txc_o && !p) begin
                per = t - last;
                last = t;
                if (k >= 0) b = {b[6:0], txd};
                if (k >= 0 || txf_o) k++;
            end
            p = txc_o;
        end
        chk(32'(b), 32'(eb));
        chk(32'(per), 32'(ep));
        chk(32'({txc_oe_n, txf_oe_n}), 32'h0000_0000);
    endtask
    task automatic close_out;
        if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(`CTRL_OFS, 32'h0000_0000, `RESP_OKAY);
        rd(8'h18, 32'h0000_0000, `RESP_SLVERR);
        wr(`STATUS_OFS, 32'h0000_0001, `RESP_SLVERR);
        wr(`SER_TX_OFS, 32'h0000_c35a, `RESP_OKAY);
        far_end_inst.send(16'hb2e1, 16, 1'b1);
        chk(32'(cap), 32'h0000_c35a);
        rd(`SER_RX_OFS, 32'h0000_b2e1, `RESP_OKAY);
        wr(`CTRL_OFS, 32'h0000_0002, `RESP_OKAY);
        wr(`SER_TX_OFS, 32'h0000_0096, `RESP_OKAY);
        far_end_inst.send(16'h0069, 8, 1'b1);
        chk(32'(cap[7:0]), 32'h0000_0096);
        rd(`SER_RX_OFS, 32'h0000_0069, `RESP_OKAY);
        wr(`CTRL_OFS, 32'h0000_0015, `RESP_OKAY);
        far_end_inst.send(16'h00c3, 8, 1'b0);
        rd(`STATUS_OFS, 32'h0000_0002, `RESP_OKAY);
        rd(`SER_RX_OFS, 32'h0000_00c3, `RESP_OKAY);
        wr(`CTRL_OFS, 32'h0000_0035, `RESP_OKAY);
        far_end_inst.send(16'h00aa, 8, 1'b0);
        rd(`STATUS_OFS, 32'h0000_0000, `RESP_OKAY);
        for (i = 0; i < 6; i++) begin
            wr(`CTRL_OFS, 32'(i * 4 + 1), `RESP_OKAY);
            wr(`SER_TX_OFS, 32'(8'h5a ^ i), `RESP_OKAY);
            grab(8'h5a ^ byte_t'(i), 2 * (`CLK_HZ / (2 * hz[i])));
        end
        wr(`PAR_TX_OFS, 32'h0000_003c, `RESP_OKAY);
        chk(32'(tx_available), 32'h0000_0001);
        host(1'b0, 8'h3c);
        chk(32'(tx_available), 32'h0000_0000);
        host(1'b1, 8'h7e);
        rd(`PAR_RX_OFS, 32'h0000_007e, `RESP_OKAY);
        close_out();
    end
    initial begin
        repeat (60000) @(posedge aclk);
        error_cnt++;
        close_out();
    end
endmodule // tb_top
